/* File: shared/tcc_defines.svh */
// Constants of the timer capture/compare pair: map, fields, resets.
// Assumes it is included by bare name from the package and modules.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_NCH        2
`define TCC_DATA_W     16
`define TCC_ADDR_W     18
`define TCC_IDX_CCA0   16'hff12
`define TCC_IDX_CCB0   16'hff14
`define TCC_IDX_CCA1   16'hffb2
`define TCC_IDX_CCB1   16'hffb4
`define TCC_IDX_CNT0   16'hff10
`define TCC_IDX_CTL0   16'hff16
`define TCC_IDX_CNT1   16'hffb0
`define TCC_IDX_CTL1   16'hffb6
`define TCC_CCA_RST    16'h0000
`define TCC_CCB_RST    16'h0000
`define TCC_CTL_RST    16'h0000
`define TCC_CTL_MASK   16'h07ff
`define TCC_CTL_RUN    0
`define TCC_CTL_MODE_A 1
`define TCC_CTL_MODE_B 2
`define TCC_CTL_SRC_A  3
`define TCC_CTL_EDGE_A 4
`define TCC_CTL_EDGE_B 6
`define TCC_CTL_DIV    8
`define TCC_CTL_TOUT   10
`define TCC_EDGE_W     2
`define TCC_DIV_W      2
`define TCC_PRE_W      3
`define TCC_SYNC_FILL  3
`endif

/* File: shared/tcc_pkg.sv */
// Types shared by the capture/compare pair and its helper modules.
// Assumes tcc_defines.svh is on the include path.
`default_nettype none
`include "tcc_defines.svh"
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_NONE = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_type;

  typedef enum logic [2:0] {
    TCC_REG_NONE = 3'h0,
    TCC_REG_CCA  = 3'h1,
    TCC_REG_CCB  = 3'h2,
    TCC_REG_CNT  = 3'h3,
    TCC_REG_CTL  = 3'h4
  } tcc_reg_type;

  typedef struct packed {
    tcc_reg_type kind;
    logic        ch;
  } tcc_dec_type;

  typedef struct packed {
    logic                   capture_mode;
    logic                   trig;
    logic                   wr_en;
    logic [`TCC_DATA_W-1:0] wr_data;
  } tcc_cc_ctl_type;

  typedef struct packed {
    logic [`TCC_DATA_W-1:0] value;
    logic                   match;
  } tcc_cc_state_type;

  typedef struct packed {
    logic [`TCC_SYNC_FILL-1:0] fill;
    logic                      s1;
    logic                      s2;
    logic                      prev;
    logic                      valid;
    logic                      opp;
  } tcc_edge_state_type;

  typedef struct packed {
    logic [`TCC_NCH-1:0][`TCC_DATA_W-1:0] ctrl;
    logic [`TCC_NCH-1:0][`TCC_DATA_W-1:0] count;
    logic [`TCC_NCH-1:0][`TCC_PRE_W-1:0]  pre;
    logic [`TCC_NCH-1:0]                  upd;
    logic [`TCC_NCH-1:0]                  tout;
    logic [31:0]                          prdata;
    logic                                 pready;
    logic                                 pslverr;
  } tcc_top_state_type;
endpackage
`default_nettype wire

/* File: verilog/tcc_edge_det.sv */
// Trigger pin synchroniser and edge detector with selectable edge.
// Assumes an asynchronous pin; edges are one-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_edge_det (
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Pin and edge choice.
  input  wire logic                  pin,
  input  wire tcc_pkg::tcc_edge_type edge_sel,
  // Edge events.
  output logic                       valid_edge,
  output logic                       opp_edge
);
  tcc_pkg::tcc_edge_state_type st_ff;
  tcc_pkg::tcc_edge_state_type nxt_st;
  logic                        rise;
  logic                        fall;

  // Edges are held off until the pipe holds real pin samples.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.s2;
    nxt_st.fill = {st_ff.fill[`TCC_SYNC_FILL-2:0], 1'b1};
    rise = st_ff.fill[`TCC_SYNC_FILL-1] & st_ff.s2 & ~st_ff.prev;
    fall = st_ff.fill[`TCC_SYNC_FILL-1] & ~st_ff.s2 & st_ff.prev;
    unique case (edge_sel)
      tcc_pkg::TCC_EDGE_FALL: begin
        nxt_st.valid = fall;
        nxt_st.opp = rise;
      end
      tcc_pkg::TCC_EDGE_RISE: begin
        nxt_st.valid = rise;
        nxt_st.opp = fall;
      end
      tcc_pkg::TCC_EDGE_NONE: begin
        nxt_st.valid = 1'b0;
        nxt_st.opp = 1'b0;
      end
      tcc_pkg::TCC_EDGE_BOTH: begin
        nxt_st.valid = rise | fall;
        nxt_st.opp = rise | fall;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign valid_edge = st_ff.valid;
  assign opp_edge = st_ff.opp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_both_edges: assert property (
    (edge_sel == tcc_pkg::TCC_EDGE_BOTH && st_ff.fill[`TCC_SYNC_FILL-1]
     && st_ff.s2 != st_ff.prev) |=> valid_edge)
    else $error("both-edge select missed an edge");
  chk_sync_latency: assert property (
    (valid_edge && $past(edge_sel) == tcc_pkg::TCC_EDGE_RISE)
    |-> ($past(pin, 3) && !$past(pin, 4)))
    else $error("rising edge not seen through two sync stages");
endmodule
`default_nettype wire

/* File: verilog/tcc_cc_unit.sv */
// One capture/compare register: compare against the count or capture it.
// Assumes count and cnt_upd come from the same clock, updated together.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_cc_unit #(
  parameter logic [`TCC_DATA_W-1:0] RST_VAL = `TCC_CCA_RST
) (
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Control and counter.
  input  wire tcc_pkg::tcc_cc_ctl_type ctl,
  input  wire logic [`TCC_DATA_W-1:0]  count,
  input  wire logic                    cnt_upd,
  // Register value and match pulse.
  output logic [`TCC_DATA_W-1:0]       value,
  output logic                         match
);
  tcc_pkg::tcc_cc_state_type st_ff;
  tcc_pkg::tcc_cc_state_type nxt_st;

  // A capture in the same cycle as a software write wins, so no edge is lost.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.match = cnt_upd && !ctl.capture_mode
                   && st_ff.value == count;
    if (ctl.capture_mode && ctl.trig) begin
      nxt_st.value = count;
    end else if (ctl.wr_en) begin
      nxt_st.value = ctl.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{value: RST_VAL, match: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.value;
  assign match = st_ff.match;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_hold_value: assert property (
    (!ctl.capture_mode && !ctl.wr_en) |=> value == $past(value))
    else $error("compare register changed without a write");
  chk_write_hold: assert property (
    (ctl.wr_en && !ctl.capture_mode) |=> value == $past(ctl.wr_data))
    else $error("written compare value not stored");
  chk_capture_copy: assert property (
    (ctl.capture_mode && ctl.trig) |=> value == $past(count))
    else $error("capture did not copy the count");
endmodule
`default_nettype wire

/* File: verilog/tcc_top.sv */
// Timer with a pair of capture/compare registers per channel, APB slave.
// Assumes one 10 MHz pclk; trigger pins are asynchronous to it.
//
// What this block does
// - Compare A equal to count raises match_irq_a.
// - Compare value holds until software rewrites it.
// - Compare mode ignores capture triggers entirely.
// - Capture A copies count on selected trigger.
// - A trigger: opposite pin-a edge or pin-b edge.
// - Compare B equal to count raises match_irq_b.
// - Capture B copies count on its trigger.
// - B trigger is pin-a edge, chosen edge select.
// - Matches never clear; the counter keeps counting.
// - Reading the count register returns current count.
// - Pin-b capture source disables the timer output.
// - Edge select code 11 detects both edges.
// - Register A resets to zero, 16-bit read/write.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_top (
  // Clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`TCC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Trigger pins, one per channel.
  input  wire logic [`TCC_NCH-1:0]    trigger_pin_a,
  input  wire logic [`TCC_NCH-1:0]    trigger_pin_b,
  // Match requests and timer outputs.
  output logic [`TCC_NCH-1:0]         match_irq_a,
  output logic [`TCC_NCH-1:0]         match_irq_b,
  output logic [`TCC_NCH-1:0]         timer_output_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // State and internal nets.

  tcc_pkg::tcc_top_state_type                       st_ff;
  tcc_pkg::tcc_top_state_type                       nxt_st;
  tcc_pkg::tcc_dec_type                             dec;
  tcc_pkg::tcc_cc_ctl_type [`TCC_NCH-1:0]           cca_ctl;
  tcc_pkg::tcc_cc_ctl_type [`TCC_NCH-1:0]           ccb_ctl;
  logic [`TCC_NCH-1:0][`TCC_DATA_W-1:0]             cca_val;
  logic [`TCC_NCH-1:0][`TCC_DATA_W-1:0]             ccb_val;
  logic [`TCC_NCH-1:0][`TCC_PRE_W-1:0]              pre_lim;
  logic [`TCC_NCH-1:0]                              match_a;
  logic [`TCC_NCH-1:0]                              match_b;
  logic [`TCC_NCH-1:0]                              valid_a;
  logic [`TCC_NCH-1:0]                              opp_a;
  logic [`TCC_NCH-1:0]                              valid_b;
  logic [`TCC_NCH-1:0]                              trig_a;
  logic [`TCC_NCH-1:0]                              trig_b;
  logic [`TCC_NCH-1:0]                              tout_block;
  logic [`TCC_DATA_W-1:0]                           rd_data;
  logic                                             setup;
  logic                                             acc_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and prescaler limits.

  // Misaligned or unknown addresses decode to nothing and answer an error.
  function automatic tcc_pkg::tcc_dec_type tcc_decode(
    input logic [`TCC_ADDR_W-1:0] addr
  );
    tcc_pkg::tcc_dec_type d;
    d.kind = tcc_pkg::TCC_REG_NONE;
    d.ch = 1'b0;
    if (addr[1:0] == 2'h0) begin
      case (addr[`TCC_ADDR_W-1:2])
        `TCC_IDX_CCA0: begin
          d.kind = tcc_pkg::TCC_REG_CCA;
        end
        `TCC_IDX_CCB0: begin
          d.kind = tcc_pkg::TCC_REG_CCB;
        end
        `TCC_IDX_CNT0: begin
          d.kind = tcc_pkg::TCC_REG_CNT;
        end
        `TCC_IDX_CTL0: begin
          d.kind = tcc_pkg::TCC_REG_CTL;
        end
        `TCC_IDX_CCA1: begin
          d.kind = tcc_pkg::TCC_REG_CCA;
          d.ch = 1'b1;
        end
        `TCC_IDX_CCB1: begin
          d.kind = tcc_pkg::TCC_REG_CCB;
          d.ch = 1'b1;
        end
        `TCC_IDX_CNT1: begin
          d.kind = tcc_pkg::TCC_REG_CNT;
          d.ch = 1'b1;
        end
        `TCC_IDX_CTL1: begin
          d.kind = tcc_pkg::TCC_REG_CTL;
          d.ch = 1'b1;
        end
        default: begin
          d.kind = tcc_pkg::TCC_REG_NONE;
        end
      endcase
    end
    return d;
  endfunction

  // The counter advances once every 1, 2, 4 or 8 clocks.
  function automatic logic [`TCC_PRE_W-1:0] tcc_pre_limit(
    input logic [`TCC_DIV_W-1:0] div
  );
    logic [`TCC_PRE_W-1:0] lim;
    lim = '0;
    case (div)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      default: lim = 3'h7;
    endcase
    return lim;
  endfunction

  assign dec = tcc_decode(paddr);
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && st_ff.pready && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  always_comb begin
    rd_data = '0;
    case (dec.kind)
      tcc_pkg::TCC_REG_CCA: rd_data = cca_val[dec.ch];
      tcc_pkg::TCC_REG_CCB: rd_data = ccb_val[dec.ch];
      tcc_pkg::TCC_REG_CNT: rd_data = st_ff.count[dec.ch];
      tcc_pkg::TCC_REG_CTL: rd_data = st_ff.ctrl[dec.ch] & `TCC_CTL_MASK;
      default: rd_data = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel slices: pin edges, trigger routing, register pair.

  for (genvar g = 0; g < `TCC_NCH; g++) begin : g_ch
    assign pre_lim[g] = tcc_pre_limit(
      st_ff.ctrl[g][`TCC_CTL_DIV +: `TCC_DIV_W]);

    tcc_edge_det u_pin_a (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin        (trigger_pin_a[g]),
      .edge_sel   (tcc_pkg::tcc_edge_type'(
                     st_ff.ctrl[g][`TCC_CTL_EDGE_A +: `TCC_EDGE_W])),
      .valid_edge (valid_a[g]),
      .opp_edge   (opp_a[g])
    );

    tcc_edge_det u_pin_b (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin        (trigger_pin_b[g]),
      .edge_sel   (tcc_pkg::tcc_edge_type'(
                     st_ff.ctrl[g][`TCC_CTL_EDGE_B +: `TCC_EDGE_W])),
      .valid_edge (valid_b[g]),
      .opp_edge   ()
    );

    assign trig_a[g] = st_ff.ctrl[g][`TCC_CTL_SRC_A] ? valid_b[g]
                                                      : opp_a[g];
    assign trig_b[g] = valid_a[g];
    assign tout_block[g] = st_ff.ctrl[g][`TCC_CTL_MODE_A]
                           && st_ff.ctrl[g][`TCC_CTL_SRC_A];

    assign cca_ctl[g] = '{
      capture_mode: st_ff.ctrl[g][`TCC_CTL_MODE_A],
      trig:         trig_a[g],
      wr_en:        acc_wr && dec.kind == tcc_pkg::TCC_REG_CCA
                    && dec.ch == 1'(g),
      wr_data:      pwdata[`TCC_DATA_W-1:0]
    };
    assign ccb_ctl[g] = '{
      capture_mode: st_ff.ctrl[g][`TCC_CTL_MODE_B],
      trig:         trig_b[g],
      wr_en:        acc_wr && dec.kind == tcc_pkg::TCC_REG_CCB
                    && dec.ch == 1'(g),
      wr_data:      pwdata[`TCC_DATA_W-1:0]
    };

    tcc_cc_unit #(
      .RST_VAL (`TCC_CCA_RST)
    ) u_cca (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (cca_ctl[g]),
      .count   (st_ff.count[g]),
      .cnt_upd (st_ff.upd[g]),
      .value   (cca_val[g]),
      .match   (match_a[g])
    );

    tcc_cc_unit #(
      .RST_VAL (`TCC_CCB_RST)
    ) u_ccb (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ccb_ctl[g]),
      .count   (st_ff.count[g]),
      .cnt_upd (st_ff.upd[g]),
      .value   (ccb_val[g]),
      .match   (match_b[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, timer output, control registers and APB answer.

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    for (int n = 0; n < `TCC_NCH; n++) begin
      nxt_st.upd[n] = 1'b0;
      // A match leaves the count alone; it simply wraps at the top.
      // The >= test keeps a lowered divider from stalling the prescaler.
      if (st_ff.ctrl[n][`TCC_CTL_RUN]) begin
        if (st_ff.pre[n] >= pre_lim[n]) begin
          nxt_st.pre[n] = '0;
          nxt_st.count[n] = 16'(st_ff.count[n] + 16'h0001);
          nxt_st.upd[n] = 1'b1;
        end else begin
          nxt_st.pre[n] = 3'(st_ff.pre[n] + 3'h1);
        end
      end else begin
        nxt_st.pre[n] = '0;
      end
      // The output toggles on each A match; pin-b capture takes it away.
      if (tout_block[n] || !st_ff.ctrl[n][`TCC_CTL_TOUT]) begin
        nxt_st.tout[n] = 1'b0;
      end else if (match_a[n]) begin
        nxt_st.tout[n] = !st_ff.tout[n];
      end
      if (acc_wr && dec.kind == tcc_pkg::TCC_REG_CTL
          && dec.ch == 1'(n)) begin
        nxt_st.ctrl[n] = pwdata[`TCC_DATA_W-1:0] & `TCC_CTL_MASK;
      end
    end
    // Read data is sampled in the setup cycle and shown in the access one.
    if (setup) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = dec.kind == tcc_pkg::TCC_REG_NONE;
      nxt_st.prdata = pwrite ? 32'h0000_0000 : {16'h0000, rd_data};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{ctrl: {`TCC_NCH{`TCC_CTL_RST}}, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign match_irq_a = match_a;
  assign match_irq_b = match_b;
  assign timer_output_pin = st_ff.tout;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar g = 0; g < `TCC_NCH; g++) begin : g_chk
    sequence s_cca_wr;
      cca_ctl[g].wr_en && !(cca_ctl[g].capture_mode && trig_a[g]);
    endsequence
    sequence s_cnt_rd;
      setup && !pwrite && dec.kind == tcc_pkg::TCC_REG_CNT
      && dec.ch == 1'(g);
    endsequence

    chk_irq_a_equal: assert property (
      (st_ff.upd[g] && !cca_ctl[g].capture_mode
       && cca_val[g] == st_ff.count[g]) |=> match_irq_a[g])
      else $error("match A not raised on equal count");
    chk_irq_b_cause: assert property (
      match_irq_b[g] |-> ($past(st_ff.upd[g])
        && $past(ccb_val[g]) == $past(st_ff.count[g])))
      else $error("match B raised without equal count");
    chk_count_keeps: assert property (
      match_irq_a[g] |=> (st_ff.count[g] == $past(st_ff.count[g])
        || st_ff.count[g] == 16'($past(st_ff.count[g]) + 16'h0001)))
      else $error("counter disturbed by a match");
    chk_count_read: assert property (
      s_cnt_rd |=> pready
        && prdata == {16'h0000, $past(st_ff.count[g])})
      else $error("count read returned a wrong value");
    chk_tout_blocked: assert property (
      tout_block[g] |=> !timer_output_pin[g])
      else $error("timer output active with pin-b capture");
    chk_cca_pin_b: assert property (
      (cca_ctl[g].capture_mode && st_ff.ctrl[g][`TCC_CTL_SRC_A]
       && valid_b[g]) |=> cca_val[g] == $past(st_ff.count[g]))
      else $error("pin-b edge did not capture into A");
    chk_ccb_pin_a: assert property (
      (ccb_ctl[g].capture_mode && valid_a[g])
      |=> ccb_val[g] == $past(st_ff.count[g]))
      else $error("pin-a edge did not capture into B");
    chk_cca_write: assert property (
      s_cca_wr |=> cca_val[g] == $past(pwdata[`TCC_DATA_W-1:0]))
      else $error("register A write not stored");

    // Undivided counting must step on every clock, match or no match.
    chk_count_runs: assert property (
      (st_ff.ctrl[g][`TCC_CTL_RUN] && pre_lim[g] == 3'h0)
      |=> st_ff.count[g] == 16'($past(st_ff.count[g]) + 16'h0001))
      else $error("counter stalled while running undivided");
    chk_irq_b_equal: assert property (
      (st_ff.upd[g] && !ccb_ctl[g].capture_mode
       && ccb_val[g] == st_ff.count[g]) |=> match_irq_b[g])
      else $error("match B not raised on equal count");
    chk_b_compare_hold: assert property (
      (!ccb_ctl[g].capture_mode && !ccb_ctl[g].wr_en)
      |=> ccb_val[g] == $past(ccb_val[g]))
      else $error("register B changed in compare mode");
  end
endmodule
`default_nettype wire

/* File: tb/tcc_trig_model.sv */
// Model of the trigger pins that feed the capture/compare pair.
// Assumes pins may change only just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_trig_model (
  // Clock.
  input  wire logic           pclk,
  // Trigger pins, one per channel.
  output logic [`TCC_NCH-1:0] pin_a = '0,
  output logic [`TCC_NCH-1:0] pin_b = '0
);
  ////////////////////////////////////////////////////////////////////////////
  // A level is held until the next call, so every edge is one clean step.
  task automatic set_pin(input logic side_b, input int ch, input logic lvl);
    @(posedge pclk);
    if (side_b) begin
      pin_b[ch] <= lvl;
    end else begin
      pin_a[ch] <= lvl;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_tcc_top.sv */
// Testbench of the capture/compare pair: APB tasks and directed tests.
// Assumes tcc_pkg, tcc_defines.svh and the trigger pin model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tb_tcc_top;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [`TCC_ADDR_W-1:0] paddr = '0;
  logic [31:0]            pwdata = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [`TCC_NCH-1:0]    pin_a;
  logic [`TCC_NCH-1:0]    pin_b;
  logic [`TCC_NCH-1:0]    irq_a;
  logic [`TCC_NCH-1:0]    irq_b;
  logic [`TCC_NCH-1:0]    tout;
  int                     n_fail = 0;
  int                     checks = 0;

  always #50 pclk = ~pclk;

  tcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_pin_a(pin_a), .trigger_pin_b(pin_b), .match_irq_a(irq_a),
    .match_irq_b(irq_b), .timer_output_pin(tout));
  tcc_trig_model trig (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The master waits for pready with a bound; no wait count is assumed.
  task automatic apb(logic w, logic [17:0] a, logic [15:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      chk("pready wait", 32'h0000_0001, 32'h0000_0000);
      give_verdict();
    end
  endtask

  task automatic wreg(logic [17:0] a, logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(logic [17:0] a, output logic [15:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 16'h0000, r, e);
    v = r[15:0];
  endtask

  task automatic rchk(string nm, logic [17:0] a, logic [15:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 16'h0000, r, e);
    chk(nm, {15'h0000, x, 1'b0}, {r[30:0], e});
  endtask

  task automatic wait_irq(logic b, int ch);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge pclk);
      if ((b ? irq_b[ch] : irq_a[ch]) === 1'b1) break;
    end
    chk("match irq seen", 32'h0000_0001, {31'h0, i < 300});
    if (i == 300) give_verdict();
  endtask

  // Runs the counter for one write so that the held count moves on.
  task automatic bump(logic [17:0] ac, logic [17:0] an, logic [15:0] c,
                      output logic [15:0] v);
    wreg(ac, c | 16'h0001);
    wreg(ac, c);
    rd(an, v);
  endtask

  function automatic logic [17:0] ad(int ch, logic [15:0] i0,
                                     logic [15:0] i1);
    return {(ch == 1 ? i1 : i0), 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [17:0] aa;
    logic [17:0] ab;
    logic [17:0] an;
    logic [17:0] ac;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [31:0] r;
    logic        e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      aa = ad(ch, `TCC_IDX_CCA0, `TCC_IDX_CCA1);
      ab = ad(ch, `TCC_IDX_CCB0, `TCC_IDX_CCB1);
      an = ad(ch, `TCC_IDX_CNT0, `TCC_IDX_CNT1);
      ac = ad(ch, `TCC_IDX_CTL0, `TCC_IDX_CTL1);
      rchk("reg a reset", aa, 16'h0000);
      rchk("reg b reset", ab, 16'h0000);
      rchk("control reset", ac, 16'h0000);
      apb(1'b0, {16'hff18, 2'b00}, 16'h0000, r, e);
      chk("unmapped read", 32'h0000_0001, {r[30:0], e});
      wreg(aa, 16'h0010);
      wreg(ab, 16'h0020);
      wreg(an, 16'h5555);
      rchk("reg a written", aa, 16'h0010);
      rchk("reg b written", ab, 16'h0020);
      rchk("count read only", an, 16'h0000);
      $display("test registers ch %0d done", ch);
      wreg(ac, 16'h04f1);
      for (int k = 0; k < 4; k++) trig.set_pin(k[1], ch, ~k[0]);
      wait_irq(1'b0, ch);
      wait_irq(1'b1, ch);
      repeat (5) @(posedge pclk);
      wreg(ac, 16'h04f0);
      rd(an, c1);
      chk("count past match", 32'h1, {31'h0, c1 > 16'h0020});
      rd(an, c2);
      chk("count read twice", {16'h0, c1}, {16'h0, c2});
      rchk("reg a in compare", aa, 16'h0010);
      rchk("reg b in compare", ab, 16'h0020);
      chk("output toggled", 32'h1, {31'h0, tout[ch]});
      $display("test compare ch %0d done", ch);
      wreg(ac, 16'h0416);
      trig.set_pin(1'b0, ch, 1'b1);
      repeat (5) @(posedge pclk);
      rchk("b on pin a rise", ab, c1);
      rchk("a waits opposite", aa, 16'h0010);
      bump(ac, an, 16'h0416, c2);
      trig.set_pin(1'b0, ch, 1'b0);
      repeat (5) @(posedge pclk);
      rchk("a on pin a fall", aa, c2);
      rchk("b holds value", ab, c1);
      chk("output kept high", 32'h1, {31'h0, tout[ch]});
      $display("test capture pin a ch %0d done", ch);
      wreg(ac, 16'h04ca);
      repeat (2) @(posedge pclk);
      chk("output forced low", 32'h0, {31'h0, tout[ch]});
      bump(ac, an, 16'h04ca, c1);
      trig.set_pin(1'b1, ch, 1'b1);
      repeat (5) @(posedge pclk);
      rchk("a on pin b rise", aa, c1);
      bump(ac, an, 16'h04ca, c2);
      trig.set_pin(1'b1, ch, 1'b0);
      repeat (5) @(posedge pclk);
      rchk("a on pin b fall", aa, c2);
      chk("output still low", 32'h0, {31'h0, tout[ch]});
      $display("test capture pin b ch %0d done", ch);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
